//--- rtl/arpt_timer.sv
/*
 * arpt_timer: 8-bit auto-reload pwm / capture timer with tap prescaler,
 * clock multiplexer and an avalon-mm register slave.
 * assumes: avalon master holds requests until waitrequest is low;
 * timer input pin is asynchronous; one system clock, i_ce freezes all.
 */
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module arpt_timer #(
    parameter int unsigned PSC_W = 7 // prescaler width, at least 7 for all taps
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [9:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_timer_input_pin,
    output logic o_pwm_out_pin,
    output logic o_pwm_out_en,
    output logic o_irq_req,
    output logic o_wake_req
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // tap n fires once every 2^n source ticks, when the low n bits wrap
    function automatic logic tap_hit(input logic [PSC_W-1:0] psc, input logic [2:0] sel);
        logic [PSC_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < PSC_W; i++) begin
            mask[i] = (i < int'(sel));
        end
        return ((psc & mask) == mask);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] mode_ctrl_q; // bit 7 never stored
    logic [7:0] clk_edge_q; // reserved bit never stored
    logic [7:0] reload_q; // reload_capture_reg
    logic [7:0] compare_q; // compare_value_reg
    logic [7:0] counter_q; // up_counter
    logic [7:0] counter_d;
    logic [PSC_W-1:0] psc_q; // tap_prescaler
    logic [PSC_W-1:0] psc_d;
    logic [1:0] div3_q; // internal clock divided by 3
    logic [2:0] flags_q; // edge, compare, overflow
    logic [2:0] flags_d;
    logic pwm_q; // pwm level
    logic pwm_d;
    logic rvalid_q; // read data ready in readdata_q
    logic [31:0] readdata_q;

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    wire [7:0] reg_idx = i_avs_address[9:2];
    wire [7:0] wdata = i_avs_writedata[7:0];
    // only the low lane carries a register; gated by clock enable
    wire wr_lane0 = i_avs_write & i_avs_byteenable[0] & i_ce;
    wire wr_mode = wr_lane0 & (reg_idx == arpt_pkg::IDX_MODE_CTRL);
    wire wr_flag = wr_lane0 & (reg_idx == arpt_pkg::IDX_FLAG_STATUS);
    wire wr_clk = wr_lane0 & (reg_idx == arpt_pkg::IDX_CLK_EDGE);
    wire wr_reload = wr_lane0 & (reg_idx == arpt_pkg::IDX_RELOAD_CAPT);
    wire wr_compare = wr_lane0 & (reg_idx == arpt_pkg::IDX_COMPARE);
    wire wr_otf = wr_lane0 & (reg_idx == arpt_pkg::IDX_OTF_LOAD);

    // read mux, unmapped indices read as zero
    wire [7:0] rd_mux =
        (reg_idx == arpt_pkg::IDX_MODE_CTRL) ? mode_ctrl_q :
        (reg_idx == arpt_pkg::IDX_FLAG_STATUS) ? {5'h00, flags_q} :
        (reg_idx == arpt_pkg::IDX_CLK_EDGE) ? clk_edge_q :
        (reg_idx == arpt_pkg::IDX_RELOAD_CAPT) ? reload_q :
        (reg_idx == arpt_pkg::IDX_COMPARE) ? compare_q :
        (reg_idx == arpt_pkg::IDX_OTF_LOAD) ? counter_q :
        8'h00;

    // reads answer one cycle late; writes stall only while frozen
    assign o_avs_waitrequest = (i_avs_read & ~rvalid_q) | (i_avs_write & ~i_ce);
    assign o_avs_readdata = readdata_q;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    arpt_pkg::arpt_mode_t op_mode;
    arpt_pkg::arpt_clk_t clk_src;
    assign op_mode = arpt_pkg::arpt_mode_t'(mode_ctrl_q[arpt_pkg::MC_MODE_LSB +: 2]);
    assign clk_src = arpt_pkg::arpt_clk_t'(clk_edge_q[arpt_pkg::CE_CLK_LSB +: 2]);
    wire count_en = mode_ctrl_q[arpt_pkg::MC_COUNT_EN];
    wire [2:0] tap_sel = clk_edge_q[arpt_pkg::CE_TAP_LSB +: 3];
    wire edge_en = clk_edge_q[arpt_pkg::CE_EDGE_EN];
    wire edge_fall = clk_edge_q[arpt_pkg::CE_POL];
    wire is_capture = op_mode inside {arpt_pkg::ARPT_MODE_CAPTURE, arpt_pkg::ARPT_MODE_CAPT_RST};

    // ------------------------------------------------------------
    // input pin and clock source
    // ------------------------------------------------------------
    logic pin_rise;
    logic pin_fall;

    arpt_pin_sync u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pin(i_timer_input_pin),
        .o_level(),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // active edge only when edge detection is on
    wire pin_edge = i_ce & edge_en & (edge_fall ? pin_fall : pin_rise);

    // source tick; the reserved selection gives no tick at all
    wire src_tick = i_ce & (
        (clk_src == arpt_pkg::ARPT_CLK_INT) |
        ((clk_src == arpt_pkg::ARPT_CLK_DIV3) & (div3_q == arpt_pkg::DIV3_LAST)) |
        ((clk_src == arpt_pkg::ARPT_CLK_PIN) & pin_rise));

    // prescaler and counter step only while counting is enabled; loads act whether or not it is
    wire psc_step = src_tick & count_en;
    wire cnt_tick = psc_step & tap_hit(psc_q, tap_sel);

    // ------------------------------------------------------------
    // load and event decode
    // ------------------------------------------------------------
    wire otf_load = wr_otf;
    // software sequence: reload value first, then strobe with enable
    wire strobe_load = wr_mode & wdata[arpt_pkg::MC_LOAD_STROBE];
    wire edge_load = pin_edge & (op_mode == arpt_pkg::ARPT_MODE_EDGE_LOAD);
    wire capture = pin_edge & is_capture;
    wire capt_rst = pin_edge & (op_mode == arpt_pkg::ARPT_MODE_CAPT_RST);
    // any load beats a count in the same cycle
    wire load_any = otf_load | strobe_load | edge_load | capt_rst;

    wire at_top = (counter_q == arpt_pkg::COUNT_TOP);
    wire ovf_evt = cnt_tick & ~load_any & at_top;
    // reload mode reloads on overflow, other modes wrap through zero
    wire [7:0] cnt_adv = !at_top ? 8'(counter_q + 8'h01) :
                         (op_mode == arpt_pkg::ARPT_MODE_RELOAD) ? reload_q :
                         8'h00;
    wire cmp_evt = cnt_tick & ~load_any & (cnt_adv == compare_q);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // counter priority: load register, reload copy, capture reset, count
    always_comb begin
        counter_d = counter_q;
        if (otf_load) begin
            counter_d = wdata;
        end else if (strobe_load | edge_load) begin
            counter_d = reload_q;
        end else if (capt_rst) begin
            counter_d = 8'h00;
        end else if (cnt_tick) begin
            counter_d = cnt_adv;
        end
    end

    // every load restarts the prescaler from zero
    assign psc_d = load_any ? '0 :
                   psc_step ? PSC_W'(psc_q + 1'b1) : psc_q;

    // hardware set wins over a software clear in the same cycle
    wire [2:0] flag_set = {capture | edge_load, cmp_evt, ovf_evt};
    wire [2:0] flag_clr = wr_flag ? ~wdata[2:0] : 3'h0;
    assign flags_d = flag_set | (flags_q & ~flag_clr);

    // match drives low and wins when it meets an overflow
    assign pwm_d = cmp_evt ? 1'b0 : ovf_evt ? 1'b1 : pwm_q;

    // ------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_ctrl_q <= arpt_pkg::MODE_CTRL_RST;
            clk_edge_q <= arpt_pkg::CLK_EDGE_RST;
            compare_q <= arpt_pkg::COMPARE_RST;
        end else begin
            if (wr_mode) begin
                mode_ctrl_q <= {1'b0, wdata[6:0]};
            end
            if (wr_clk) begin
                clk_edge_q <= wdata & ~(8'h01 << arpt_pkg::CE_RSVD);
            end
            if (wr_compare) begin
                compare_q <= wdata;
            end
        end
    end

    // reload/capture register: a capture beats a software write
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            reload_q <= arpt_pkg::RELOAD_RST;
        end else if (capture) begin
            reload_q <= counter_q;
        end else if (wr_reload) begin
            reload_q <= wdata;
        end
    end

    // ------------------------------------------------------------
    // timer core state
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            counter_q <= arpt_pkg::COUNTER_RST;
            psc_q <= '0;
            div3_q <= 2'h0;
            flags_q <= arpt_pkg::FLAGS_RST;
            pwm_q <= 1'b0;
        end else if (i_ce) begin
            counter_q <= counter_d;
            psc_q <= psc_d;
            div3_q <= (div3_q == arpt_pkg::DIV3_LAST) ? 2'h0 : 2'(div3_q + 2'h1);
            flags_q <= flags_d;
            pwm_q <= pwm_d;
        end
    end

    // ------------------------------------------------------------
    // bus read answer
    // ------------------------------------------------------------
    // rvalid drops after one cycle so back-to-back reads each wait once
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rvalid_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            rvalid_q <= i_avs_read & ~rvalid_q;
            if (i_avs_read & ~rvalid_q) begin
                readdata_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire [2:0] irq_en = mode_ctrl_q[arpt_pkg::MC_OVF_IE +: 3]; // edge, compare, overflow
    assign o_irq_req = |(flags_q & irq_en);
    // limitation: stop-mode wake still needs i_clk_sys for the pin path
    assign o_wake_req = o_irq_req;
    assign o_pwm_out_pin = pwm_q;
    assign o_pwm_out_en = mode_ctrl_q[arpt_pkg::MC_PWM_OE];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_loaded_zero_psc;
        (psc_q == '0);
    endsequence

    count_up_a: assert property (
        cnt_tick && !load_any && !at_top |=> counter_q == 8'($past(counter_q) + 8'h01))
        else $error("counter did not step by one");
    freeze_off_a: assert property (
        i_ce && !count_en && !load_any |=> $stable(counter_q) && $stable(psc_q))
        else $error("counter or prescaler moved while disabled");
    otf_load_a: assert property (
        wr_otf |=> (counter_q == $past(wdata)) ##0 s_loaded_zero_psc)
        else $error("load register write not copied to counter");
    psc_clear_a: assert property (
        load_any |=> s_loaded_zero_psc)
        else $error("prescaler not cleared on load");
    reload_ovf_a: assert property (
        ovf_evt && op_mode == arpt_pkg::ARPT_MODE_RELOAD |=>
            counter_q == $past(reload_q) && flags_q[arpt_pkg::FS_OVF])
        else $error("overflow did not reload and flag");
    cmp_pwm_low_a: assert property (
        cmp_evt |=> !pwm_q && flags_q[arpt_pkg::FS_CMP] && !o_pwm_out_pin)
        else $error("compare match did not clear pwm and flag");
    ovf_pwm_high_a: assert property (
        ovf_evt && !cmp_evt |=> pwm_q ##1 (pwm_q || $past(cmp_evt)))
        else $error("overflow did not raise pwm");
    capture_copy_a: assert property (
        capture |=> reload_q == $past(counter_q) && flags_q[arpt_pkg::FS_EDGE])
        else $error("capture did not copy count or set flag");
    capt_reset_a: assert property (
        capt_rst && !otf_load && !strobe_load |=> counter_q == 8'h00 && psc_q == '0)
        else $error("capture-reset did not clear counter");
    edge_load_a: assert property (
        edge_load && !otf_load |=> counter_q == $past(reload_q))
        else $error("edge load did not copy reload value");
    ovf_only_clr_a: assert property (
        wr_flag && wdata == 8'h06 && flags_q[arpt_pkg::FS_EDGE] |=>
            flags_q[arpt_pkg::FS_EDGE])
        else $error("edge flag lost by overflow-only clear");
    flag_clear_a: assert property (
        wr_flag && !wdata[arpt_pkg::FS_OVF] && !ovf_evt |=> !flags_q[arpt_pkg::FS_OVF])
        else $error("zero write did not clear overflow flag");
    strobe_zero_a: assert property (
        rvalid_q && reg_idx == arpt_pkg::IDX_MODE_CTRL |-> !o_avs_readdata[7])
        else $error("load strobe read back as one");

endmodule

`default_nettype wire

//--- rtl/arpt_pkg.sv
/*
 * arpt_pkg: constants and types shared by the auto-reload pwm/capture timer.
 * assumes: every user writes arpt_pkg::name, nothing is imported.
 */
`default_nettype none

package arpt_pkg;

    // ------------------------------------------------------------
    // register word indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MODE_CTRL = 8'hD5; // mode_control_reg
    localparam logic [7:0] IDX_FLAG_STATUS = 8'hD6; // flag_status_reg
    localparam logic [7:0] IDX_CLK_EDGE = 8'hD7; // clock_edge_config_reg
    localparam logic [7:0] IDX_RELOAD_CAPT = 8'hD9; // reload_capture_reg
    localparam logic [7:0] IDX_COMPARE = 8'hDA; // compare_value_reg
    localparam logic [7:0] IDX_OTF_LOAD = 8'hDB; // on_the_fly_load_reg

    // ------------------------------------------------------------
    // mode_control_reg field positions
    // ------------------------------------------------------------
    localparam int unsigned MC_LOAD_STROBE = 7; // load_strobe_bit, write only
    localparam int unsigned MC_COUNT_EN = 6; // count_enable_bit
    localparam int unsigned MC_PWM_OE = 5; // pwm output enable
    localparam int unsigned MC_EDGE_IE = 4; // edge_irq_enable
    localparam int unsigned MC_CMP_IE = 3; // compare_irq_enable
    localparam int unsigned MC_OVF_IE = 2; // overflow_irq_enable
    localparam int unsigned MC_MODE_LSB = 0; // operating_mode_field, 2 bits

    // ------------------------------------------------------------
    // flag_status_reg field positions
    // ------------------------------------------------------------
    localparam int unsigned FS_EDGE = 2; // edge_event_flag
    localparam int unsigned FS_CMP = 1; // compare_flag
    localparam int unsigned FS_OVF = 0; // overflow_flag

    // ------------------------------------------------------------
    // clock_edge_config_reg field positions
    // ------------------------------------------------------------
    localparam int unsigned CE_TAP_LSB = 5; // tap_select_field, 3 bits
    localparam int unsigned CE_RSVD = 4; // reserved, reads zero
    localparam int unsigned CE_POL = 3; // edge_polarity_select
    localparam int unsigned CE_EDGE_EN = 2; // edge_detect_enable
    localparam int unsigned CE_CLK_LSB = 0; // clock_select_field, 2 bits

    // ------------------------------------------------------------
    // values after reset and counts
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] CLK_EDGE_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;
    localparam logic [7:0] COUNTER_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [1:0] DIV3_LAST = 2'h2; // divide-by-3 counter wraps here
    localparam logic [7:0] COUNT_TOP = 8'hFF; // last count before overflow

    // operating modes in field order
    typedef enum logic [1:0] {
        ARPT_MODE_RELOAD,
        ARPT_MODE_CAPTURE,
        ARPT_MODE_CAPT_RST,
        ARPT_MODE_EDGE_LOAD
    } arpt_mode_t;

    // clock sources in field order
    typedef enum logic [1:0] {
        ARPT_CLK_INT,
        ARPT_CLK_DIV3,
        ARPT_CLK_PIN,
        ARPT_CLK_RSVD
    } arpt_clk_t;

endpackage

`default_nettype wire

//--- rtl/arpt_pin_sync.sv
/*
 * arpt_pin_sync: three-stage synchroniser with agreement filter and
 * edge pulses for the timer input pin.
 * assumes: pin is asynchronous to i_clk_sys; i_ce freezes every stage.
 */
`timescale 1ns/100ps
`default_nettype none

module arpt_pin_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic meta_q; // first stage, read by stage two only
    logic sync2_q; // second stage
    logic sync3_q; // third stage
    logic level_q; // filtered level
    logic level_d;
    logic prev_q; // filtered level one enabled cycle ago

    // a change counts only once stage two and three agree
    assign level_d = (sync2_q == sync3_q) ? sync2_q : level_q;

    // shift chain and filter
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            level_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (i_ce) begin
            meta_q <= i_pin;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
            prev_q <= level_q;
        end
    end

    // one pulse per filtered change, so one event per edge
    assign o_level = level_q;
    assign o_rise = level_q & ~prev_q;
    assign o_fall = ~level_q & prev_q;

endmodule

`default_nettype wire

//--- sim/arpt_far_side.sv
/*
 * arpt_far_side: pulse source on the timer input pin and a pwm load that
 * counts rising pwm edges.
 * assumes: the bench calls pulse() right after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

module arpt_far_side (
    input wire logic i_clk_sys,
    input wire logic i_pwm_out_pin,
    output logic o_pin,
    output logic [7:0] o_pwm_rises
);
    logic pwm_q = 1'b0; // pwm level one cycle ago
    initial o_pin = 1'b0; // pin rests low, as with a pull-down
    initial o_pwm_rises = 8'h00;

    // load side: count every low-to-high step of the pwm pin
    always @(posedge i_clk_sys) begin
        pwm_q <= i_pwm_out_pin;
        if (i_pwm_out_pin && !pwm_q) o_pwm_rises <= o_pwm_rises + 8'h01;
    end

    // n pulses of 8 high and 8 low cycles, wide enough for the pin filter
    task automatic pulse(input int n);
        repeat (n) begin
            o_pin <= 1'b1;
            repeat (8) @(posedge i_clk_sys);
            o_pin <= 1'b0;
            repeat (8) @(posedge i_clk_sys);
        end
    endtask
endmodule

`default_nettype wire

//--- sim/test_arpt_timer.sv
/*
 * test_arpt_timer: register-level tests of the pwm/capture timer.
 * assumes: arpt_far_side drives the input pin and watches the pwm pin.
 */
`timescale 1ns/100ps
`default_nettype none

module test_arpt_timer;
    localparam logic [7:0] MC = arpt_pkg::IDX_MODE_CTRL;
    localparam logic [7:0] FS = arpt_pkg::IDX_FLAG_STATUS;
    localparam logic [7:0] CE = arpt_pkg::IDX_CLK_EDGE;
    localparam logic [7:0] RC = arpt_pkg::IDX_RELOAD_CAPT;
    localparam logic [7:0] CP = arpt_pkg::IDX_COMPARE;
    localparam logic [7:0] LD = arpt_pkg::IDX_OTF_LOAD;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic wait_req;
    logic pin;
    logic pwm;
    logic pwm_en;
    logic irq;
    logic wake;
    logic [7:0] rises;
    logic [7:0] r0;
    int fail_count = 0;
    int checks = 0;

    always #12.5 clk = ~clk; // 40 MHz

    arpt_timer arpt_timer_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .i_timer_input_pin(pin), .o_pwm_out_pin(pwm),
        .o_pwm_out_en(pwm_en), .o_irq_req(irq), .o_wake_req(wake));
    arpt_far_side arpt_far_side_inst (.i_clk_sys(clk), .i_pwm_out_pin(pwm),
        .o_pin(pin), .o_pwm_rises(rises));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon access; an idle edge first keeps strobes from double drives
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            final_report();
        end
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        check(q, exp);
    endtask

    // count from zero for a while (cycles or pin pulses), stop, read twice
    task automatic rate(input logic [7:0] cfg, input int cyc, input int np,
        input logic [7:0] exp);
        wreg(MC, 8'h00);
        wreg(CE, cfg);
        wreg(LD, 8'h00);
        wreg(MC, 8'h40);
        if (np > 0) arpt_far_side_inst.pulse(np);
        else repeat (cyc) @(posedge clk);
        wreg(MC, 8'h00);
        rchk(LD, exp);
        repeat (20) @(posedge clk);
        rchk(LD, exp);
    endtask

    // one pin pulse in a given mode; a slow tap, or count enable off, keeps the count still meanwhile
    task automatic edge_case(input logic [7:0] mode, input logic [7:0] cfg,
        input logic [7:0] otf, input logic [7:0] rl, input logic [7:0] cnt,
        input logic [7:0] fl);
        wreg(FS, 8'h00);
        wreg(CE, cfg);
        wreg(RC, 8'h77);
        wreg(LD, otf);
        wreg(MC, mode);
        arpt_far_side_inst.pulse(1);
        rchk(RC, rl);
        rchk(LD, cnt);
        rchk(FS, fl);
    endtask

    task automatic final_report;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // every register, the count and unmapped words read zero
        for (int i = 'hD4; i <= 'hDC; i++) rchk(8'(i), 8'h00);
        rate(8'hE0, 704, 0, 8'h05);
        rate(8'hA1, 336, 0, 8'h03);
        rate(8'h02, 0, 6, 8'h06);
        rate(8'h03, 40, 0, 8'h00);
        // clock enable low freezes the running count as well
        wreg(CE, 8'h00);
        wreg(LD, 8'h00);
        wreg(MC, 8'h40);
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wreg(MC, 8'h00);
        rchk(LD, 8'h02);
        // pwm: reload F0, compare F8, 16 ticks a period
        wreg(CE, 8'h00);
        wreg(RC, 8'hF0);
        wreg(CP, 8'hF8);
        r0 = rises;
        wreg(MC, 8'hE4);
        rchk(MC, 8'h64);
        repeat (164) @(posedge clk);
        wreg(MC, 8'h24);
        check(rises - r0, 8'h0A);
        check({7'h00, pwm_en}, 8'h01);
        rchk(FS, 8'h03);
        check({6'h00, wake, irq}, 8'h03);
        wreg(FS, 8'h06);
        rchk(FS, 8'h02);
        check({7'h00, irq}, 8'h00);
        wreg(MC, 8'h28);
        @(posedge clk);
        check({7'h00, irq}, 8'h01);
        wreg(FS, 8'h05);
        rchk(FS, 8'h00);
        edge_case(8'h51, 8'hE4, 8'h40, 8'h40, 8'h40, 8'h04);
        check({7'h00, irq}, 8'h01);
        wreg(FS, 8'h06);
        rchk(FS, 8'h04);
        edge_case(8'h51, 8'hE0, 8'h50, 8'h77, 8'h50, 8'h00);
        edge_case(8'h51, 8'hEC, 8'h60, 8'h60, 8'h60, 8'h04);
        edge_case(8'h52, 8'hE4, 8'h30, 8'h30, 8'h00, 8'h04);
        edge_case(8'h03, 8'h04, 8'h11, 8'h77, 8'h77, 8'h04);
        // reset in mid-run returns the count and reload value to zero
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rchk(LD, 8'h00);
        rchk(RC, 8'h00);
        final_report();
    end

    // watchdog: the whole run needs under 2500 cycles
    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule

`default_nettype wire
